// >>> logic/brf_defines.svh
`ifndef BRF_DEFINES_SVH
`define BRF_DEFINES_SVH
// word offsets relative to the assigned base word
`define BRF_OFF_LINE_STATUS   7'd0
`define BRF_OFF_PARAM_STATUS  7'd1
`define BRF_OFF_BANK_STATUS   7'd2
`define BRF_OFF_IMAGE_FIRST   7'd4
`define BRF_OFF_IMAGE_LAST    7'd19
`define BRF_OFF_RSV_FIRST     7'd20
// line status word bit positions
`define BRF_BIT_READY         0
`define BRF_BIT_SHORT         1
`define BRF_BIT_DROP          3
`define BRF_BIT_BREAK         4
`define BRF_BIT_OVERCOUNT     6
`define BRF_BIT_HS_CAPABLE    10
`define BRF_BIT_BUSY          11
`define BRF_BIT_ADJUST        15
// param/alarm status word bit positions
`define BRF_BIT_ALARM         0
`define BRF_BIT_DONE          1
`define BRF_BIT_PERR          2
`define BRF_BIT_DETECT        4
// command bit positions
`define BRF_BIT_ERR_CLR       0
`define BRF_BIT_ADDR_DET      1
`define BRF_BIT_SINGLE        0
`define BRF_BIT_BATCH_RD      1
`define BRF_BIT_BATCH_WR      2
`define BRF_BIT_BANK_SEL      0
`define BRF_BIT_BANK_SW       1
// slave count limit without wide host support
`define BRF_NARROW_MAX_SLAVES 9'd128
`define BRF_RESET_WORD        16'h0000
`endif

// >>> logic/brf_pkg.sv
`default_nettype none
package brf_pkg;
    typedef struct packed {
        logic short_det;
        logic drop_det;
        logic break_det;
        logic hw_fail;
        logic self_test_done;
        logic adjust_mode;
        logic slave_alarm;
        logic param_err;
    } brf_fault_t;

    typedef struct packed {
        logic work_done;
        logic detect_done;
        logic bank_done;
    } brf_done_t;

    typedef enum logic [2:0] {
        BRF_P_IDLE = 3'b001,
        BRF_P_WORK = 3'b010,
        BRF_P_HOLD = 3'b100
    } brf_pstate_t;
endpackage : brf_pkg
`default_nettype wire

// >>> logic/brf_error_latch.sv
`timescale 1ns/1ps
`default_nettype none
module brf_error_latch
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // set and clear
    input  wire logic set_in,
    input  wire logic clr_in,
    // flag
    output logic      flag_q
);
    // set wins over clear so no event is lost
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            flag_q <= 1'b0;
        else if (set_in)
            flag_q <= 1'b1;
        else if (clr_in)
            flag_q <= 1'b0;
    end
endmodule : brf_error_latch
`default_nettype wire

// >>> logic/brf_remote_io.sv
// Contract
// - ready rises after power-on once self test has ended
// - ready drops while an internal hardware failure is seen
// - short error sets on wire short or supply overcurrent
// - short error latched until cured, then reset or clear pulse
// - supply drop error sets when field supply voltage falls
// - drop error latched until cured, then reset or clear pulse
// - break error sets on wire break or lost slave, except in adjust mode
// - break error latched until cured, then reset or clear pulse
// - overcount error sets when narrow host and 129 or more slaves
// - overcount clears after count at most 128 and address detection
// - overcount clears with wide host after detection or reset
// - handshake capable bit is always one
// - busy sets when any parameter command processing starts
// - input points 0..255 in words base+4..19, point 0 at bit 0
// - output points from words base+4..19 forwarded to slaves
// - line status word bit layout, reserved bits zero
// - param status word bit layout, reserved bits zero
// - word 2: bank shown and switching; select and switch commands
// - words relative to base; offsets 20 to 127 reserved
// - busy drops after processing done and all commands low
// - bank low shows slaves 1-128, high shows 129-256
`timescale 1ns/1ps
`default_nettype none
`include "brf_defines.svh"
module brf_remote_io
    import brf_pkg::*;
#(
    parameter int POINTS = 256,
    parameter int WORDS  = 16
)
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // master side word access
    input  wire logic [6:0]  rx_addr,
    output logic      [15:0] rx_data_q,
    input  wire logic        wr_en,
    input  wire logic [6:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    // sensor bus side
    input  wire logic [POINTS-1:0] slave_in_points,
    output logic      [POINTS-1:0] slave_out_points_q,
    input  wire brf_fault_t  fault_in,
    input  wire brf_done_t   done_in,
    input  wire logic        wide_host,
    input  wire logic [8:0]  slave_count,
    // command strobes to the engines
    output logic             param_start,
    output logic             detect_start,
    output logic             bank_start,
    output logic             bank_sel_q
);
    // the word map is fixed at sixteen image words of sixteen points
    if (POINTS != 256 || WORDS * 16 != POINTS)
    begin : g_bad_size
        $error("brf_remote_io: unsupported point count");
    end

    logic [15:0]       cmd0_q;
    logic [15:0]       cmd1_q;
    logic [15:0]       cmd2_q;
    logic              ready_q;
    logic              over_q;
    logic              detect_q;
    logic              switch_q;
    logic              bank_q;
    logic              done_q;
    logic              clr_prev_q;
    logic              det_prev_q;
    logic              sw_prev_q;
    logic              sw_done_q;
    logic              perr_q;
    logic              alarm_q;
    logic              short_q;
    logic              drop_q;
    logic              break_q;
    brf_pstate_t       pst_q;
    brf_pstate_t       pst_d;

    // decode of master commands, reserved bits never looked at
    wire clr_req   = cmd0_q[`BRF_BIT_ERR_CLR];
    wire det_req   = cmd0_q[`BRF_BIT_ADDR_DET];
    wire any_param = cmd1_q[`BRF_BIT_SINGLE] |
                     cmd1_q[`BRF_BIT_BATCH_RD] |
                     cmd1_q[`BRF_BIT_BATCH_WR];
    wire sw_req    = cmd2_q[`BRF_BIT_BANK_SW];
    wire clr_fall  = clr_prev_q & ~clr_req;
    wire det_rise  = det_req & ~det_prev_q;
    wire sw_rise   = sw_req & ~sw_prev_q;
    wire over_cond = ~wide_host & (slave_count > `BRF_NARROW_MAX_SLAVES);

    // write side: words relative to base, reserved region dropped
    wire wr_cmd0 = wr_en && wr_addr == `BRF_OFF_LINE_STATUS;
    wire wr_cmd1 = wr_en && wr_addr == `BRF_OFF_PARAM_STATUS;
    wire wr_cmd2 = wr_en && wr_addr == `BRF_OFF_BANK_STATUS;
    wire wr_img  = wr_en && wr_addr >= `BRF_OFF_IMAGE_FIRST &&
                   wr_addr <= `BRF_OFF_IMAGE_LAST;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            cmd0_q <= `BRF_RESET_WORD;
            cmd1_q <= `BRF_RESET_WORD;
            cmd2_q <= `BRF_RESET_WORD;
        end
        else
        begin
            if (wr_cmd0)
                cmd0_q <= wr_data;
            if (wr_cmd1)
                cmd1_q <= wr_data;
            if (wr_cmd2)
                cmd2_q <= wr_data;
        end
    end

    // output image, one word slice per generate entry
    genvar gi;
    generate
        for (gi = 0; gi < WORDS; gi++)
        begin : g_out
            wire hit = wr_img &&
                wr_addr == 7'(`BRF_OFF_IMAGE_FIRST + gi);
            always_ff @(posedge ref_clk)
            begin
                if (!nrst)
                    slave_out_points_q[gi*16 +: 16] <= `BRF_RESET_WORD;
                else if (hit)
                    slave_out_points_q[gi*16 +: 16] <= wr_data;
            end
        end
    endgenerate

    // latched faults and alarms; clear only on the fall and only if cured
    brf_error_latch u_short
    (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .set_in  (fault_in.short_det),
        .clr_in  (clr_fall & ~fault_in.short_det),
        .flag_q  (short_q)
    );
    brf_error_latch u_drop
    (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .set_in  (fault_in.drop_det),
        .clr_in  (clr_fall & ~fault_in.drop_det),
        .flag_q  (drop_q)
    );
    brf_error_latch u_break
    (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        // adjust mode hides disconnection detection
        .set_in  (fault_in.break_det & ~fault_in.adjust_mode),
        .clr_in  (clr_fall & ~fault_in.break_det),
        .flag_q  (break_q)
    );
    brf_error_latch u_alarm
    (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .set_in  (fault_in.slave_alarm),
        .clr_in  (clr_fall & ~fault_in.slave_alarm),
        .flag_q  (alarm_q)
    );
    brf_error_latch u_perr
    (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .set_in  (fault_in.param_err),
        .clr_in  (clr_fall & ~fault_in.param_err),
        .flag_q  (perr_q)
    );

    // parameter access handshake
    always_comb
    begin
        pst_d = pst_q;
        unique case (pst_q)
            BRF_P_IDLE:
                if (any_param)
                    pst_d = BRF_P_WORK;
            BRF_P_WORK:
                if (done_in.work_done)
                    pst_d = BRF_P_HOLD;
            BRF_P_HOLD:
                if (!any_param)
                    pst_d = BRF_P_IDLE;
            default:
                pst_d = BRF_P_IDLE;
        endcase
    end

    wire busy = pst_q != BRF_P_IDLE;
    assign param_start  = pst_q == BRF_P_IDLE && any_param &&
                          !fault_in.adjust_mode;
    assign detect_start = det_rise;
    assign bank_start   = sw_rise;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            pst_q      <= BRF_P_IDLE;
            ready_q    <= 1'b0;
            over_q     <= 1'b0;
            detect_q   <= 1'b0;
            switch_q   <= 1'b0;
            bank_q     <= 1'b0;
            bank_sel_q <= 1'b0;
            done_q     <= 1'b0;
            clr_prev_q <= 1'b0;
            det_prev_q <= 1'b0;
            sw_prev_q  <= 1'b0;
            sw_done_q  <= 1'b0;
        end
        else
        begin
            // adjust mode blocks new parameter work
            if (!(pst_q == BRF_P_IDLE && fault_in.adjust_mode))
                pst_q <= pst_d;
            ready_q    <= fault_in.self_test_done & ~fault_in.hw_fail;
            clr_prev_q <= clr_req;
            det_prev_q <= det_req;
            sw_prev_q  <= sw_req;
            if (pst_q == BRF_P_WORK && done_in.work_done)
                done_q <= 1'b1;
            else if (param_start)
                done_q <= 1'b0;
            if (det_rise)
                detect_q <= 1'b1;
            else if (done_in.detect_done)
                detect_q <= 1'b0;
            // overcount sets at once outside detection; cleared only at end of address detection
            if (over_cond && !detect_q)
                over_q <= 1'b1;
            else if (detect_q && done_in.detect_done)
                over_q <= over_cond;
            // done pulse kept so a command held past it still ends the switch
            if (sw_rise)
            begin
                switch_q   <= 1'b1;
                sw_done_q  <= 1'b0;
                bank_sel_q <= cmd2_q[`BRF_BIT_BANK_SEL];
            end
            else if (switch_q && (done_in.bank_done || sw_done_q) && !sw_req)
            begin
                switch_q <= 1'b0;
                bank_q   <= bank_sel_q;
            end
            else if (switch_q && done_in.bank_done)
                sw_done_q <= 1'b1;
        end
    end

    // status words; every bit not named reads zero
    logic [15:0] st0;
    logic [15:0] st1;
    logic [15:0] st2;
    always_comb
    begin
        st0 = `BRF_RESET_WORD;
        st0[`BRF_BIT_READY]      = ready_q;
        st0[`BRF_BIT_SHORT]      = short_q;
        st0[`BRF_BIT_DROP]       = drop_q;
        st0[`BRF_BIT_BREAK]      = break_q;
        st0[`BRF_BIT_OVERCOUNT]  = over_q;
        st0[`BRF_BIT_HS_CAPABLE] = 1'b1;
        st0[`BRF_BIT_BUSY]       = busy;
        st0[`BRF_BIT_ADJUST]     = fault_in.adjust_mode;
        st1 = `BRF_RESET_WORD;
        st1[`BRF_BIT_ALARM]  = alarm_q;
        st1[`BRF_BIT_DONE]   = done_q;
        st1[`BRF_BIT_PERR]   = perr_q;
        st1[`BRF_BIT_DETECT] = detect_q;
        st2 = `BRF_RESET_WORD;
        st2[`BRF_BIT_BANK_SEL] = bank_q;
        st2[`BRF_BIT_BANK_SW]  = switch_q;
    end

    wire [6:0]  img_idx  = rx_addr - `BRF_OFF_IMAGE_FIRST;
    wire        rd_img   = rx_addr >= `BRF_OFF_IMAGE_FIRST &&
                           rx_addr <= `BRF_OFF_IMAGE_LAST;
    wire [15:0] img_word = slave_in_points[img_idx[3:0]*16 +: 16];
    wire [15:0] rd_mux   =
        rx_addr == `BRF_OFF_LINE_STATUS  ? st0 :
        rx_addr == `BRF_OFF_PARAM_STATUS ? st1 :
        rx_addr == `BRF_OFF_BANK_STATUS  ? st2 :
        rd_img ? img_word : `BRF_RESET_WORD;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            rx_data_q <= `BRF_RESET_WORD;
        else
            rx_data_q <= rd_mux;
    end
endmodule : brf_remote_io
`default_nettype wire

// >>> bench/brf_remote_io_sva.sv
`timescale 1ns/1ps
`default_nettype none
module brf_remote_io_sva
    import brf_pkg::*;
#(
    parameter int POINTS = 256
)
(
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              nrst,
    // word access
    input wire logic [6:0]        rx_addr,
    input wire logic [15:0]       rx_data_q,
    input wire logic              wr_en,
    input wire logic [6:0]        wr_addr,
    input wire logic [15:0]       wr_data,
    // sensor bus side
    input wire logic [POINTS-1:0] slave_in_points,
    input wire logic [POINTS-1:0] slave_out_points_q,
    input wire brf_fault_t        fault_in,
    // strobes
    input wire logic              param_start,
    input wire logic              detect_start,
    input wire logic              bank_start
);
    logic [6:0]        wa_q;
    wire logic [15:0]  img_w;
    wire logic [15:0]  out_w;
    wire logic         rdy_w;
    assign img_w = slave_in_points[16*(rx_addr-7'd4) +: 16];
    assign out_w = slave_out_points_q[16*(wa_q-7'd4) +: 16];
    assign rdy_w = fault_in.self_test_done & ~fault_in.hw_fail;
    always_ff @(posedge ref_clk)
        wa_q <= wr_addr;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    rsv_read_zero_a: assert property (rx_addr >= 7'd20 || rx_addr == 7'd3 |=>
        rx_data_q == 16'h0000) else $error("reserved word not zero");
    hs_capable_a: assert property (rx_addr == 7'd0 |=> rx_data_q[10])
        else $error("handshake capable bit low");
    status_rsv_a: assert property (rx_addr == 7'd0 |=>
        (rx_data_q & 16'h73a4) == 16'h0000) else $error("status reserved set");
    param_rsv_a: assert property (rx_addr == 7'd1 |=>
        (rx_data_q & 16'hffe8) == 16'h0000) else $error("param reserved set");
    in_image_a: assert property (rx_addr inside {[7'd4:7'd19]} |=>
        rx_data_q == $past(img_w)) else $error("input image word wrong");
    out_image_a: assert property (wr_en && wr_addr inside {[7'd4:7'd19]} |=>
        out_w == $past(wr_data)) else $error("output image word wrong");
    ready_track_a: assert property (rx_addr == 7'd0 && $past(nrst) |=>
        rx_data_q[0] == $past(rdy_w, 2)) else $error("ready bit wrong");
    busy_set_a: assert property (param_start ##1 rx_addr == 7'd0 |=>
        rx_data_q[11]) else $error("busy not set");
    param_pulse_a: assert property (param_start |=> !param_start)
        else $error("parameter strobe longer than one cycle");
    detect_pulse_a: assert property (detect_start |->
        $past(wr_en && wr_addr == 7'd0 && wr_data[1]) ##1 !detect_start)
        else $error("detect strobe without request");
    bank_pulse_a: assert property (bank_start |->
        $past(wr_en && wr_addr == 7'd2 && wr_data[1]) ##1 !bank_start)
        else $error("bank strobe without request");
endmodule : brf_remote_io_sva
bind brf_remote_io brf_remote_io_sva #(.POINTS(POINTS)) i_sva (
    .ref_clk(ref_clk), .nrst(nrst), .rx_addr(rx_addr),
    .rx_data_q(rx_data_q), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .slave_in_points(slave_in_points),
    .slave_out_points_q(slave_out_points_q), .fault_in(fault_in),
    .param_start(param_start), .detect_start(detect_start),
    .bank_start(bank_start));
`default_nettype wire

// >>> bench/brf_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module brf_engine_model
    import brf_pkg::*;
#(
    parameter int LAT = 6
)
(
    // clock and reset
    input  wire logic      ref_clk,
    input  wire logic      nrst,
    // start strobes
    input  wire logic      param_start,
    input  wire logic      detect_start,
    input  wire logic      bank_start,
    // completion pulses
    output wire brf_done_t done_out
);
    // fixed latency only; a slower engine is a larger LAT
    logic [LAT-1:0] p_q, d_q, b_q;
    always_ff @(posedge ref_clk)
    begin
        p_q <= nrst ? {p_q[LAT-2:0], param_start} : '0;
        d_q <= nrst ? {d_q[LAT-2:0], detect_start} : '0;
        b_q <= nrst ? {b_q[LAT-2:0], bank_start} : '0;
    end
    assign done_out.work_done   = p_q[LAT-1];
    assign done_out.detect_done = d_q[LAT-1];
    assign done_out.bank_done   = b_q[LAT-1];
endmodule : brf_engine_model
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import brf_pkg::*;
    localparam int LAT = 6;
    logic ref_clk, nrst, wr_en, wide_host;
    logic [6:0] rx_addr, wr_addr;
    logic [15:0] wr_data, rx_data_q, m;
    logic [255:0] slave_in_points, slave_out_points_q;
    logic [8:0] slave_count;
    logic param_start, detect_start, bank_start, bank_sel_q;
    brf_fault_t fault_in;
    brf_done_t done_in;
    int error_cnt, checks, fb, sb;
    brf_remote_io i_dut (.ref_clk(ref_clk), .nrst(nrst), .rx_addr(rx_addr),
        .rx_data_q(rx_data_q), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .slave_in_points(slave_in_points),
        .slave_out_points_q(slave_out_points_q), .fault_in(fault_in),
        .done_in(done_in), .wide_host(wide_host), .slave_count(slave_count),
        .param_start(param_start), .detect_start(detect_start),
        .bank_start(bank_start), .bank_sel_q(bank_sel_q));
    brf_engine_model #(.LAT(LAT)) i_eng (.ref_clk(ref_clk), .nrst(nrst),
        .param_start(param_start), .detect_start(detect_start),
        .bank_start(bank_start), .done_out(done_in));
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge ref_clk);
        wr_en = 1'b0;
    endtask : wr
    task automatic rdc(input logic [6:0] a, input logic [15:0] e,
                       input logic [15:0] msk);
        @(negedge ref_clk);
        rx_addr = a;
        @(negedge ref_clk);
        cmp(rx_data_q & msk, e);
    endtask : rdc
    task automatic clr;
        wr(7'd0, 16'h0001);
        wr(7'd0, 16'h0000);
    endtask : clr
    task automatic detect;
        wr(7'd0, 16'h0002);
        rdc(7'd1, 16'h0010, 16'h0010);
        repeat (LAT + 2) @(negedge ref_clk);
        rdc(7'd1, 16'h0000, 16'h0010);
        wr(7'd0, 16'h0000);
    endtask : detect
    initial
    begin
        // watchdog: a hang counts as a mismatch
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        end_sim();
    end
    initial
    begin
        {nrst, wr_en, wide_host, rx_addr, wr_addr, wr_data} = '0;
        {slave_in_points, fault_in, error_cnt, checks} = '0;
        slave_count = 9'd0;
        repeat (4) @(negedge ref_clk);
        nrst = 1'b1;
        rdc(7'd0, 16'h0400, 16'hffff);
        fault_in.self_test_done = 1'b1;
        rdc(7'd0, 16'h0401, 16'hffff);
        fault_in.hw_fail = 1'b1;
        rdc(7'd0, 16'h0000, 16'h0001);
        fault_in.hw_fail = 1'b0;
        fault_in.adjust_mode = 1'b1;
        rdc(7'd0, 16'h8000, 16'h8000);
        fault_in.adjust_mode = 1'b0;
        rdc(7'd3, 16'h0000, 16'hffff);
        rdc(7'd20, 16'h0000, 16'hffff);
        rdc(7'd127, 16'h0000, 16'hffff);
        $display("test status done");
        for (int i = 0; i < 3; i++)
        begin
            fb = 7 - i;
            sb = (i == 0) ? 1 : i + 2;
            m = 16'h0001 << sb;
            fault_in[fb] = 1'b1;
            rdc(7'd0, m, m);
            clr();
            rdc(7'd0, m, m);
            fault_in[fb] = 1'b0;
            rdc(7'd0, m, m);
            clr();
            rdc(7'd0, 16'h0000, m);
        end
        $display("test latched errors done");
        slave_count = 9'd129;
        rdc(7'd0, 16'h0040, 16'h0040);
        slave_count = 9'd128;
        detect();
        rdc(7'd0, 16'h0000, 16'h0040);
        slave_count = 9'd129;
        rdc(7'd0, 16'h0040, 16'h0040);
        wide_host = 1'b1;
        detect();
        rdc(7'd0, 16'h0000, 16'h0040);
        $display("test overcount done");
        wr(7'd1, 16'hfff8);
        rdc(7'd0, 16'h0000, 16'h0800);
        for (int i = 0; i < 3; i++)
        begin
            wr(7'd1, 16'h0001 << i);
            rdc(7'd0, 16'h0800, 16'h0800);
            repeat (LAT + 2) @(negedge ref_clk);
            rdc(7'd0, 16'h0800, 16'h0800);
            rdc(7'd1, 16'h0002, 16'h0002);
            wr(7'd1, 16'h0000);
            rdc(7'd0, 16'h0000, 16'h0800);
        end
        fault_in.slave_alarm = 1'b1;
        fault_in.param_err = 1'b1;
        rdc(7'd1, 16'h0005, 16'h0005);
        $display("test parameter access done");
        for (int k = 0; k < 16; k++)
            slave_in_points[16*k +: 16] = {k[3:0], 12'h5a3};
        for (int k = 0; k < 16; k++)
            rdc(7'(4 + k), {k[3:0], 12'h5a3}, 16'hffff);
        for (int k = 0; k < 16; k++)
        begin
            wr(7'(4 + k), {12'ha5c, k[3:0]});
            cmp(slave_out_points_q[16*k +: 16], {12'ha5c, k[3:0]});
        end
        $display("test point images done");
        wr(7'd2, 16'h0001);
        wr(7'd2, 16'h0003);
        rdc(7'd2, 16'h0002, 16'h0002);
        wr(7'd2, 16'h0001);
        repeat (LAT) @(negedge ref_clk);
        rdc(7'd2, 16'h0001, 16'h0003);
        cmp({15'h0000, bank_sel_q}, 16'h0001);
        // switch command held high past the engine's done pulse
        wr(7'd2, 16'h0002);
        repeat (LAT + 2) @(negedge ref_clk);
        rdc(7'd2, 16'h0003, 16'h0003);
        wr(7'd2, 16'h0000);
        rdc(7'd2, 16'h0000, 16'h0003);
        cmp({15'h0000, bank_sel_q}, 16'h0000);
        $display("test bank switch done");
        end_sim();
    end
endmodule : testbench
`default_nettype wire
